// *** verilog/slt_pkg.sv ***
// constants and carrier types for the serial link timer block
// assumes a single reference clock; no register bus beyond the documented ports
package slt_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  SLT_PORT_LINK_TIMEOUT_CONTROL_OFS = 8'h20;
  localparam int          SLT_TOV_LSB                       = 8;
  localparam int          SLT_TOV_W                         = 24;
  localparam logic [23:0] SLT_TOV_RESET                     = 24'hFF_FFFF;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          SLT_CLK_MHZ        = 125;
  localparam int          SLT_PRESCALE_DIV   = 32;
  localparam int          SLT_SILENCE_US     = 120;
  localparam int          SLT_SILENCE_CYC    = SLT_SILENCE_US * SLT_CLK_MHZ;
  localparam int          SLT_DISC_UNIT_CYC  = 131071;
  localparam int          SLT_DISC_W         = 4;
  localparam logic [3:0]  SLT_DISC_RESET     = 4'h9;
  localparam int          SLT_SIL_CNT_W      = 15;
  localparam int          SLT_DISC_CNT_W     = 17;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } slt_reg_req_t;

  typedef struct packed {
    logic start;  // packet or link-request sent: restart the wait
    logic done;   // acknowledge or link-response seen: end the wait
  } slt_link_evt_t;

endpackage : slt_pkg

// *** verilog/slt_timers.sv ***
// serial link timers: shared link time-out, silence timer and discovery timer
// assumes request inputs come from logic on SYS_CLK_I; time-out register reached by the plain register port, prescale field by its own write port
`timescale 1ns/1ps

module slt_timers
  import slt_pkg::*;
(
  input  wire logic          SYS_CLK_I,
  input  wire logic          RST_N_I,
  input  wire slt_reg_req_t  REG_REQ_I,
  output logic [31:0]        REG_RDATA_O,
  input  wire slt_link_evt_t ACK_EVT_I,
  input  wire slt_link_evt_t LRSP_EVT_I,
  output logic               ACK_TIMEOUT_O,
  output logic               LRSP_TIMEOUT_O,
  input  wire logic          SILENT_STATE_I,
  input  wire logic          SILENCE_TIMER_START_I,
  output logic               SILENCE_TIMER_EN_O,
  output logic               SILENCE_TIMER_DONE_O,
  input  wire logic          DISCOVERY_STATE_I,
  input  wire logic          DISCOVERY_TIMER_START_I,
  input  wire logic          PORT_4X_I,
  input  wire logic [3:0]    DISC_PRESCALE_I,
  input  wire logic          DISC_PRESCALE_WR_I,
  output logic [3:0]         DISC_PRESCALE_O,
  output logic               DISCOVERY_TIMER_EN_O,
  output logic               DISCOVERY_TIMER_DONE_O
);

  // ----------------------------------------
  // shared time-out register
  // ----------------------------------------
  logic [23:0] timeout_count_value;
  logic [4:0]  tick_div;
  logic        tick;

  // one setting for all ports
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      timeout_count_value <= SLT_TOV_RESET;
    end else if (REG_REQ_I.wr && REG_REQ_I.addr == SLT_PORT_LINK_TIMEOUT_CONTROL_OFS) begin
      timeout_count_value <= REG_REQ_I.wdata[SLT_TOV_LSB +: SLT_TOV_W];
    end
  end

  // register read data
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_REQ_I.rd && REG_REQ_I.addr == SLT_PORT_LINK_TIMEOUT_CONTROL_OFS) begin
      REG_RDATA_O <= {timeout_count_value, 8'h00};
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
    end
  end

  // divide-by-32 free-running prescaler
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      tick_div <= 5'h00;
    end else begin
      tick_div <= tick_div + 5'h01;
    end
  end
  assign tick = (tick_div == 5'(SLT_PRESCALE_DIV - 1));

  // ----------------------------------------
  // two link waits: acknowledge and link-response
  // ----------------------------------------
  slt_link_evt_t evt [2];
  logic [1:0]    tmo;
  assign evt[0] = ACK_EVT_I;
  assign evt[1] = LRSP_EVT_I;

  for (genvar g = 0; g < 2; g++) begin : g_wait
    logic        busy;
    logic        expire;
    logic        tmo_q;
    logic [23:0] cnt;

    // this tick completes the programmed number of ticks
    assign expire = busy && tick && (cnt + 24'h00_0001 >= timeout_count_value);

    // counter restarts on each new start event
    always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
        busy <= 1'b0;
        cnt  <= 24'h00_0000;
      end else if (evt[g].start) begin
        busy <= 1'b1;
        cnt  <= 24'h00_0000;
      end else if (evt[g].done || expire) begin
        busy <= 1'b0;
      end else if (busy && tick) begin
        cnt <= cnt + 24'h00_0001;
      end
    end

    // one-cycle time-out pulse; a start or done in the same cycle suppresses it
    always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
        tmo_q <= 1'b0;
      end else if (evt[g].start || evt[g].done) begin
        tmo_q <= 1'b0;
      end else begin
        tmo_q <= expire;
      end
    end
    assign tmo[g] = tmo_q;
  end
  assign ACK_TIMEOUT_O  = tmo[0];
  assign LRSP_TIMEOUT_O = tmo[1];

  // ----------------------------------------
  // silence timer
  // ----------------------------------------
  logic [14:0] sil_cnt;
  logic        sil_begin;
  logic        sil_last;

  // start only from idle; after done a new request waits for a fresh silent state
  assign sil_begin = SILENT_STATE_I && SILENCE_TIMER_START_I && !SILENCE_TIMER_EN_O && !SILENCE_TIMER_DONE_O;
  // last cycle of the fixed span
  assign sil_last  = SILENCE_TIMER_EN_O && (sil_cnt == 15'(SLT_SILENCE_CYC - 1));

  // fixed count on the reference clock, no programming
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      sil_cnt <= 15'h0000;
    end else if (!SILENT_STATE_I || sil_begin) begin
      sil_cnt <= 15'h0000;
    end else if (SILENCE_TIMER_EN_O && !sil_last) begin
      sil_cnt <= sil_cnt + 15'h0001;
    end
  end

  // enable: raised on a start, dropped at expiry or on leaving the silent state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      SILENCE_TIMER_EN_O <= 1'b0;
    end else if (!SILENT_STATE_I || sil_last) begin
      SILENCE_TIMER_EN_O <= 1'b0;
    end else if (sil_begin) begin
      SILENCE_TIMER_EN_O <= 1'b1;
    end
  end

  // done: set at expiry, held until the silent state ends
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      SILENCE_TIMER_DONE_O <= 1'b0;
    end else if (!SILENT_STATE_I) begin
      SILENCE_TIMER_DONE_O <= 1'b0;
    end else if (sil_last) begin
      SILENCE_TIMER_DONE_O <= 1'b1;
    end
  end

  // ----------------------------------------
  // discovery timer
  // ----------------------------------------
  logic [16:0] disc_cnt;
  logic [3:0]  disc_pre;
  logic        disc_begin;
  logic        disc_unit_end;
  logic        disc_last;

  // prescale field, software writable
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      DISC_PRESCALE_O <= SLT_DISC_RESET;
    end else if (DISC_PRESCALE_WR_I) begin
      DISC_PRESCALE_O <= DISC_PRESCALE_I;
    end
  end

  // start only on a four-lane port, from idle
  assign disc_begin    = DISCOVERY_STATE_I && DISCOVERY_TIMER_START_I && PORT_4X_I
                         && !DISCOVERY_TIMER_EN_O && !DISCOVERY_TIMER_DONE_O;
  // end of one prescale unit of 131071 cycles
  assign disc_unit_end = DISCOVERY_TIMER_EN_O && (disc_cnt == 17'(SLT_DISC_UNIT_CYC - 1));
  // last unit; a field of zero behaves as one unit
  assign disc_last     = disc_unit_end && (disc_pre + 4'h1 >= DISC_PRESCALE_O);

  // cycle count within one prescale unit
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      disc_cnt <= 17'h0_0000;
    end else if (!DISCOVERY_STATE_I || disc_begin || disc_unit_end) begin
      disc_cnt <= 17'h0_0000;
    end else if (DISCOVERY_TIMER_EN_O) begin
      disc_cnt <= disc_cnt + 17'h0_0001;
    end
  end

  // count of finished prescale units
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      disc_pre <= 4'h0;
    end else if (!DISCOVERY_STATE_I || disc_begin) begin
      disc_pre <= 4'h0;
    end else if (disc_unit_end && !disc_last) begin
      disc_pre <= disc_pre + 4'h1;
    end
  end

  // enable: raised on a start, dropped at expiry or on leaving the discovery state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      DISCOVERY_TIMER_EN_O <= 1'b0;
    end else if (!DISCOVERY_STATE_I || disc_last) begin
      DISCOVERY_TIMER_EN_O <= 1'b0;
    end else if (disc_begin) begin
      DISCOVERY_TIMER_EN_O <= 1'b1;
    end
  end

  // done: set at expiry, held until the discovery state ends
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      DISCOVERY_TIMER_DONE_O <= 1'b0;
    end else if (!DISCOVERY_STATE_I) begin
      DISCOVERY_TIMER_DONE_O <= 1'b0;
    end else if (disc_last) begin
      DISCOVERY_TIMER_DONE_O <= 1'b1;
    end
  end

endmodule : slt_timers

// *** tb/slt_timers_props.sv ***
// concurrent checks on the serial link timer ports
// assumes the port names of slt_timers and one clock
`timescale 1ns/1ps
module slt_timers_chk
  import slt_pkg::*;
(
  input wire logic       SYS_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       ACK_TIMEOUT_O,
  input wire logic       SILENT_STATE_I,
  input wire logic       SILENCE_TIMER_EN_O,
  input wire logic       SILENCE_TIMER_DONE_O,
  input wire logic       DISCOVERY_STATE_I,
  input wire logic       PORT_4X_I,
  input wire logic [3:0] DISC_PRESCALE_I,
  input wire logic       DISC_PRESCALE_WR_I,
  input wire logic [3:0] DISC_PRESCALE_O,
  input wire logic       DISCOVERY_TIMER_EN_O,
  input wire logic       DISCOVERY_TIMER_DONE_O
);
  logic [15:0] sil_cnt;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // cycles the silence enable has stood high
  always_ff @(posedge SYS_CLK_I) begin
    sil_cnt <= SILENCE_TIMER_EN_O ? sil_cnt + 16'h0001 : 16'h0000;
  end
  a_sil_span: assert property ($rose(SILENCE_TIMER_DONE_O) |-> sil_cnt inside {[16'h2710:16'h4E20]})
    else $error("silence done outside its span");
  a_sil_stop: assert property ($rose(SILENCE_TIMER_DONE_O) |-> !SILENCE_TIMER_EN_O)
    else $error("silence enable high at done");
  a_sil_out: assert property (!SILENT_STATE_I |=> !SILENCE_TIMER_DONE_O)
    else $error("silence done outside silent state");
  a_disc_out: assert property (!DISCOVERY_STATE_I |=> !DISCOVERY_TIMER_DONE_O)
    else $error("discovery done outside discovery state");
  a_disc_lanes: assert property ($rose(DISCOVERY_TIMER_EN_O) |-> $past(PORT_4X_I) && $past(DISCOVERY_STATE_I))
    else $error("discovery timer started without four lanes");
  a_pre_reset: assert property ($rose(RST_N_I) |-> DISC_PRESCALE_O == SLT_DISC_RESET)
    else $error("prescale reset value wrong");
  a_pre_write: assert property (DISC_PRESCALE_WR_I |=> DISC_PRESCALE_O == $past(DISC_PRESCALE_I))
    else $error("prescale write lost");
  a_tmo_pulse: assert property (ACK_TIMEOUT_O |=> !ACK_TIMEOUT_O)
    else $error("time-out pulse too long");
endmodule : slt_timers_chk

bind slt_timers slt_timers_chk chk (.*);

// *** tb/slt_init_model.sv ***
// model of the port initialization machine facing the state timers
// assumes go requests from the bench on the reference clock
`timescale 1ns/1ps
module slt_init_model (
  input  wire logic clk_i,
  input  wire logic sil_go_i,
  input  wire logic disc_go_i,
  input  wire logic sil_en_i,
  input  wire logic disc_en_i,
  output logic      silent_o = 1'b0,
  output logic      sil_start_o = 1'b0,
  output logic      disc_o = 1'b0,
  output logic      disc_start_o = 1'b0
);
  // hold the state while asked, request the timer until it runs
  always @(posedge clk_i) begin
    silent_o     <= sil_go_i;
    sil_start_o  <= sil_go_i && !sil_en_i;
    disc_o       <= disc_go_i;
    disc_start_o <= disc_go_i && !disc_en_i;
  end
endmodule : slt_init_model

// *** tb/serial_link_timers_bench.sv ***
// self-checking bench: count register, link waits, silence and discovery
// assumes slt_init_model plays the initialization machine
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin n_fail++; $display("Error %0t %h %h", $time, a, b); end end
module serial_link_timers_bench;
  import slt_pkg::*;
  logic clk = 0, rst_n = 0, sil_go = 0, disc_go = 0, p4x = 0, pwr = 0;
  logic silent, sstart, disc, dstart, s_en, s_done, d_en, d_done, ack_to, lrsp_to;
  logic [3:0] pre = 4'h0, pre_o;
  logic [31:0] rdata, rd_val;
  slt_reg_req_t req = '0;
  slt_link_evt_t ack = '0, lrsp = '0;
  int n_fail = 0, tests_run = 0, k, n;
  always #4 clk = ~clk;
  slt_timers dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req), .REG_RDATA_O(rdata), .ACK_EVT_I(ack),
    .LRSP_EVT_I(lrsp), .ACK_TIMEOUT_O(ack_to), .LRSP_TIMEOUT_O(lrsp_to), .SILENT_STATE_I(silent),
    .SILENCE_TIMER_START_I(sstart), .SILENCE_TIMER_EN_O(s_en), .SILENCE_TIMER_DONE_O(s_done),
    .DISCOVERY_STATE_I(disc), .DISCOVERY_TIMER_START_I(dstart), .PORT_4X_I(p4x), .DISC_PRESCALE_I(pre),
    .DISC_PRESCALE_WR_I(pwr), .DISC_PRESCALE_O(pre_o), .DISCOVERY_TIMER_EN_O(d_en), .DISCOVERY_TIMER_DONE_O(d_done));
  slt_init_model peer (.clk_i(clk), .sil_go_i(sil_go), .disc_go_i(disc_go), .sil_en_i(s_en), .disc_en_i(d_en),
    .silent_o(silent), .sil_start_o(sstart), .disc_o(disc), .disc_start_o(dstart));
  // time-out window for n ticks of 32 cycles
  function automatic bit tmo_ok(int c, int t);
    return c >= 32 * (t - 1) && c <= 32 * t + 2;
  endfunction
  task automatic cyc(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // one register cycle; read data stands just after the taking edge
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    req <= '{w, !w, a, d};
    cyc(1);
    rd_val = rdata;
    req <= '0;
    cyc(1);
  endtask
  // start one wait and count cycles to its time-out
  task automatic wait_to(bit lr);
    if (lr) lrsp.start <= 1'b1;
    else ack.start <= 1'b1;
    cyc(1);
    lrsp <= '0;
    ack <= '0;
    for (k = 1; k < 400 && (lr ? lrsp_to : ack_to) !== 1'b1; k++) cyc(1);
  endtask
  initial begin
    void'($urandom(1346));
    cyc(20);
    rst_n <= 1;
    cyc(1);
    acc(0, SLT_PORT_LINK_TIMEOUT_CONTROL_OFS, '0);
    `CHK(rd_val, {SLT_TOV_RESET, 8'h00})
    `CHK(pre_o, SLT_DISC_RESET)
    acc(0, 8'h24, '0);
    `CHK(rd_val, 32'h0000_0000)
    $display("test reset done");
    repeat (3) begin
      n = 2 + $urandom % 4;
      acc(1, SLT_PORT_LINK_TIMEOUT_CONTROL_OFS, {n[23:0], 8'h00});
      acc(0, SLT_PORT_LINK_TIMEOUT_CONTROL_OFS, '0);
      `CHK(rd_val, {n[23:0], 8'h00})
      wait_to(0);
      `CHK(tmo_ok(k, n), 1'b1)
      wait_to(1);
      `CHK(tmo_ok(k, n), 1'b1)
    end
    // acknowledge arrives in time: no time-out
    ack <= '{1'b1, 1'b0};
    cyc(1);
    ack <= '{1'b0, 1'b1};
    cyc(1);
    ack <= '0;
    k = 0;
    repeat (200) begin
      cyc(1);
      if (ack_to === 1'b1) k++;
    end
    `CHK(k, 0)
    pre <= 4'($urandom);
    pwr <= 1;
    cyc(1);
    pwr <= 0;
    cyc(1);
    `CHK(pre_o, pre)
    $display("test link done");
    sil_go <= 1;
    for (k = 0; k < 20 && s_en !== 1'b1; k++) cyc(1);
    for (k = 0; k < 16000 && s_done !== 1'b1; k++) cyc(1);
    `CHK(k, SLT_SILENCE_CYC)
    `CHK(s_en, 1'b0)
    sil_go <= 0;
    cyc(3);
    `CHK(s_done, 1'b0)
    // one-lane port refused, then four lanes accepted
    disc_go <= 1;
    cyc(6);
    `CHK(d_en, 1'b0)
    p4x <= 1;
    cyc(4);
    `CHK(d_en, 1'b1)
    disc_go <= 0;
    cyc(3);
    `CHK(d_done, 1'b0)
    `CHK(d_en, 1'b0)
    $display("test init done");
    complete_run();
  end
  initial begin
    #400000;
    n_fail++;
    complete_run();
  end
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
endmodule : serial_link_timers_bench
